// file: rtl/btmc_regs.sv
// Bus transceiver mode control registers with serial register port
// What this block does
// - Bit 7 disables LIN slope control
// - Bit 6 selects LIN low slope
// - Bit 5 enables LIN transmit time-out
// - Bits 4:3 set first LIN mode
// - Bits 2:0 set CAN mode, selective wake
// - Hardware never alters CAN selective wake bit
// - Slope bits take effect at select release
// - Sleep without system error: CAN normal to wake
// - CAN receive-only: wake on Sleep, kept on Stop
// - CAN off or wake kept on Sleep/Stop
// - Fail-safe loads wake-capable defaults
// - Restart keeps top bits, loads cause modes
// - Auxiliary bit 5 selects regulator peak threshold
// - Peak bit writable only in Init/Normal
// - Ignored peak write raises no error or interrupt
// - Auxiliary bits 1:0 set second LIN mode
// - Auxiliary reserved bits read zero
// - Global option: all status bits interrupt
`timescale 1ns/1ps
`include "btmc_consts.svh"
module btmc_regs (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic chip_select_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic init_normal_mode_i,
  input wire logic stop_mode_i,
  input wire logic system_error_flag_i,
  input wire logic sleep_entry_i,
  input wire logic stop_entry_i,
  input wire logic failsafe_entry_i,
  input wire logic restart_entry_i,
  input wire logic [1:0] restart_lin_mode_i,
  input wire logic [1:0] restart_can_mode_i,
  input wire logic [1:0] restart_second_lin_mode_i,
  input wire logic wake_event_i,
  input wire logic status_event_i,
  input wire logic global_interrupt_i,
  output logic lin_flash_o,
  output logic low_slope_select_o,
  output logic transmit_timeout_enable_o,
  output logic [1:0] lin_mode_o,
  output logic [1:0] can_mode_o,
  output logic selective_wake_o,
  output logic [1:0] second_local_bus_mode_o,
  output logic regulator_peak_threshold_o,
  output logic spi_fail_o,
  output logic external_wake_load_o,
  output logic int_o
);
  // ****************************************
  // Serial port
  // ****************************************
  btmc_frame_if fr ();
  btmc_spi_frame u_port (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .chip_select_n_i(chip_select_n_i),
    .sclk_i(sclk_i),
    .sdi_i(sdi_i),
    .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o),
    .fr(fr)
  );
  // ****************************************
  // Read decode
  // ****************************************
  function automatic logic [7:0] rd_reg(input logic [6:0] a, input logic [7:0] b1,
                                        input logic pk, input logic [1:0] l2);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `BTMC_ADDR_BUS_CTRL: r = b1;
      `BTMC_ADDR_BUS_AUX: begin
        // Reserved positions stay zero
        r[`BTMC_PEAK_BIT] = pk;
        r[`BTMC_SECOND_LOCAL_BUS_MODE_HI:`BTMC_SECOND_LOCAL_BUS_MODE_LO] = l2;
      end
      default: r = 8'h00;
    endcase
    return r;
  endfunction
  // ****************************************
  // Register bank
  // ****************************************
  logic [7:0] bus_ff, nxt_bus;
  logic peak_ff, nxt_peak;
  logic [1:0] second_local_bus_mode_ff, nxt_second_local_bus_mode;
  logic fail_ff, nxt_fail, ext_ff, nxt_ext, int_ff, nxt_int;
  logic wr_ok, wr_bus, wr_aux, peak_open, hw_evt;
  btmc_pkg::btmc_mode_t can_lo;
  // Named copies so that single fields can be selected from the reset and fail-safe words
  localparam logic [7:0] aux_rst_val = `BTMC_BUS_AUX_RST;
  localparam logic [7:0] aux_fs_val = `BTMC_BUS_AUX_FS;
  assign wr_ok = fr.frame_done & fr.frame_ok & fr.is_write;
  assign wr_bus = wr_ok & (fr.addr == `BTMC_ADDR_BUS_CTRL);
  assign wr_aux = wr_ok & (fr.addr == `BTMC_ADDR_BUS_AUX);
  assign peak_open = init_normal_mode_i & ~stop_mode_i;
  assign hw_evt = sleep_entry_i | stop_entry_i | failsafe_entry_i | restart_entry_i;
  assign can_lo = bus_ff[`BTMC_CAN_HI:`BTMC_CAN_LO];
  assign fr.rdata = rd_reg(fr.rd_addr, bus_ff, peak_ff, second_local_bus_mode_ff);
  always_comb begin
    nxt_bus = bus_ff;
    nxt_peak = peak_ff;
    nxt_second_local_bus_mode = second_local_bus_mode_ff;
    nxt_fail = 1'b0;
    nxt_ext = 1'b0;
    // Only wake sources interrupt unless the global option is set
    nxt_int = wake_event_i | (global_interrupt_i & status_event_i);
    if (wr_bus) begin
      // Whole register written; slope bits act at once
      nxt_bus = fr.wdata;
    end
    if (wr_aux) begin
      nxt_second_local_bus_mode = fr.wdata[`BTMC_SECOND_LOCAL_BUS_MODE_HI:`BTMC_SECOND_LOCAL_BUS_MODE_LO];
      if (peak_open) begin
        nxt_peak = fr.wdata[`BTMC_PEAK_BIT];
      end
    end
    // A refused peak write is silent; only malformed frames flag
    if (fr.frame_done && !fr.frame_ok) begin
      nxt_fail = 1'b1;
    end
    // Mode events win over a write in the same cycle
    if (sleep_entry_i) begin
      if (can_lo == `BTMC_MODE_NORMAL && !system_error_flag_i) begin
        nxt_bus[`BTMC_CAN_HI:`BTMC_CAN_LO] = `BTMC_MODE_WAKE;
      end else if (can_lo == `BTMC_MODE_RX) begin
        nxt_bus[`BTMC_CAN_HI:`BTMC_CAN_LO] = `BTMC_MODE_WAKE;
      end else begin
        nxt_bus[`BTMC_CAN_HI:`BTMC_CAN_LO] = can_lo;
      end
    end
    if (stop_entry_i) begin
      // Stop keeps every CAN mode, receive-only included
      nxt_bus[`BTMC_CAN_HI:`BTMC_CAN_LO] = can_lo;
    end
    if (restart_entry_i) begin
      nxt_bus[`BTMC_LIN1_HI:`BTMC_LIN1_LO] = restart_lin_mode_i;
      nxt_bus[`BTMC_CAN_HI:`BTMC_CAN_LO] = restart_can_mode_i;
      nxt_second_local_bus_mode = restart_second_lin_mode_i;
    end
    if (failsafe_entry_i) begin
      // Selective wake bit kept so that only software ever moves it
      nxt_bus[`BTMC_LIN1_HI:`BTMC_LIN1_LO] = `BTMC_MODE_WAKE;
      nxt_bus[`BTMC_CAN_HI:`BTMC_CAN_LO] = `BTMC_MODE_WAKE;
      nxt_peak = aux_fs_val[`BTMC_PEAK_BIT];
      nxt_second_local_bus_mode = `BTMC_MODE_WAKE;
      nxt_ext = 1'b1;
    end
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      bus_ff <= `BTMC_BUS_CTRL_RST;
      peak_ff <= aux_rst_val[`BTMC_PEAK_BIT];
      second_local_bus_mode_ff <= aux_rst_val[`BTMC_SECOND_LOCAL_BUS_MODE_HI:`BTMC_SECOND_LOCAL_BUS_MODE_LO];
      fail_ff <= 1'b0;
      ext_ff <= 1'b0;
      int_ff <= 1'b0;
    end else begin
      bus_ff <= nxt_bus;
      peak_ff <= nxt_peak;
      second_local_bus_mode_ff <= nxt_second_local_bus_mode;
      fail_ff <= nxt_fail;
      ext_ff <= nxt_ext;
      int_ff <= nxt_int;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  assign lin_flash_o = bus_ff[`BTMC_FLASH_BIT];
  assign low_slope_select_o = bus_ff[`BTMC_LSM_BIT];
  assign transmit_timeout_enable_o = bus_ff[`BTMC_TXTO_BIT];
  assign lin_mode_o = bus_ff[`BTMC_LIN1_HI:`BTMC_LIN1_LO];
  assign can_mode_o = bus_ff[`BTMC_CAN_HI:`BTMC_CAN_LO];
  assign selective_wake_o = bus_ff[`BTMC_SWK_BIT];
  assign second_local_bus_mode_o = second_local_bus_mode_ff;
  assign regulator_peak_threshold_o = peak_ff;
  assign spi_fail_o = fail_ff;
  assign external_wake_load_o = ext_ff;
  assign int_o = int_ff;
  // ****************************************
  // Assertions
  // ****************************************
  sequence s_bus_write;
    wr_bus && !hw_evt;
  endsequence
  property p_flash_follows;
    @(posedge mclk_i) disable iff (reset_i)
    s_bus_write |=> lin_flash_o == $past(fr.wdata[`BTMC_FLASH_BIT]);
  endproperty
  a_flash_follows: assert property (p_flash_follows)
    else $error("Flash bit did not follow write");
  property p_slope_follows;
    @(posedge mclk_i) disable iff (reset_i)
    s_bus_write |=> low_slope_select_o == $past(fr.wdata[`BTMC_LSM_BIT]);
  endproperty
  a_slope_follows: assert property (p_slope_follows)
    else $error("Low slope bit did not follow write");
  property p_swk_sw_only;
    @(posedge mclk_i) disable iff (reset_i)
    !wr_bus |=> $stable(selective_wake_o);
  endproperty
  a_swk_sw_only: assert property (p_swk_sw_only)
    else $error("Selective wake bit moved without a write");
  property p_sleep_normal;
    @(posedge mclk_i) disable iff (reset_i)
    (sleep_entry_i && !system_error_flag_i && can_mode_o == `BTMC_MODE_NORMAL
     && !failsafe_entry_i && !restart_entry_i) |=> can_mode_o == `BTMC_MODE_WAKE;
  endproperty
  a_sleep_normal: assert property (p_sleep_normal)
    else $error("Normal CAN not moved to wake on Sleep");
  property p_stop_rx_kept;
    @(posedge mclk_i) disable iff (reset_i)
    (stop_entry_i && !sleep_entry_i && !failsafe_entry_i && !restart_entry_i
     && can_mode_o == `BTMC_MODE_RX) |=> can_mode_o == `BTMC_MODE_RX;
  endproperty
  a_stop_rx_kept: assert property (p_stop_rx_kept)
    else $error("Receive-only CAN changed on Stop");
  property p_low_modes_kept;
    @(posedge mclk_i) disable iff (reset_i)
    ((sleep_entry_i || stop_entry_i) && !failsafe_entry_i && !restart_entry_i
     && can_mode_o[1] == 1'b0) |=> $stable(can_mode_o);
  endproperty
  a_low_modes_kept: assert property (p_low_modes_kept)
    else $error("Off or wake CAN mode changed on low power entry");
  property p_failsafe_load;
    @(posedge mclk_i) disable iff (reset_i)
    failsafe_entry_i |=> (lin_mode_o == `BTMC_MODE_WAKE) && (can_mode_o == `BTMC_MODE_WAKE)
      && (second_local_bus_mode_o == `BTMC_MODE_WAKE) && !regulator_peak_threshold_o
      && external_wake_load_o ##1 !external_wake_load_o;
  endproperty
  a_failsafe_load: assert property (p_failsafe_load)
    else $error("Fail-safe defaults not loaded");
  property p_peak_locked;
    @(posedge mclk_i) disable iff (reset_i)
    (wr_aux && stop_mode_i && !failsafe_entry_i) |=> $stable(regulator_peak_threshold_o)
      && !spi_fail_o;
  endproperty
  a_peak_locked: assert property (p_peak_locked)
    else $error("Peak bit written in Stop or error raised");
  property p_aux_reserved;
    @(posedge mclk_i) disable iff (reset_i)
    (fr.rd_addr == `BTMC_ADDR_BUS_AUX) |-> (fr.rdata & `BTMC_AUX_ZERO_MASK) == 8'h00;
  endproperty
  a_aux_reserved: assert property (p_aux_reserved)
    else $error("Reserved auxiliary bits read nonzero");
  property p_wake_int;
    @(posedge mclk_i) disable iff (reset_i)
    (wake_event_i || (global_interrupt_i && status_event_i)) |=> int_o
      ##1 (int_o == $past(wake_event_i || (global_interrupt_i && status_event_i)));
  endproperty
  a_wake_int: assert property (p_wake_int)
    else $error("Interrupt not raised for enabled source");
  property p_txto_follows;
    @(posedge mclk_i) disable iff (reset_i)
    s_bus_write |=> transmit_timeout_enable_o == $past(fr.wdata[`BTMC_TXTO_BIT]);
  endproperty
  a_txto_follows: assert property (p_txto_follows)
    else $error("Time-out enable did not follow write");
  property p_lin_follows;
    @(posedge mclk_i) disable iff (reset_i)
    s_bus_write |=> lin_mode_o == $past(fr.wdata[`BTMC_LIN1_HI:`BTMC_LIN1_LO]);
  endproperty
  a_lin_follows: assert property (p_lin_follows)
    else $error("First LIN mode did not follow write");
  property p_can_follows;
    @(posedge mclk_i) disable iff (reset_i)
    s_bus_write |=> (can_mode_o == $past(fr.wdata[`BTMC_CAN_HI:`BTMC_CAN_LO]))
      && (selective_wake_o == $past(fr.wdata[`BTMC_SWK_BIT]));
  endproperty
  a_can_follows: assert property (p_can_follows)
    else $error("CAN mode did not follow write");
  sequence s_restart_only;
    restart_entry_i && !failsafe_entry_i && !wr_bus;
  endsequence
  property p_restart_load;
    @(posedge mclk_i) disable iff (reset_i)
    s_restart_only |=> (lin_mode_o == $past(restart_lin_mode_i))
      && (can_mode_o == $past(restart_can_mode_i))
      && (second_local_bus_mode_o == $past(restart_second_lin_mode_i))
      && $stable(bus_ff[`BTMC_FLASH_BIT:`BTMC_TXTO_BIT]) && $stable(selective_wake_o);
  endproperty
  a_restart_load: assert property (p_restart_load)
    else $error("Restart modes not loaded or upper bits moved");
  property p_peak_open;
    @(posedge mclk_i) disable iff (reset_i)
    (wr_aux && peak_open && !failsafe_entry_i)
      |=> regulator_peak_threshold_o == $past(fr.wdata[`BTMC_PEAK_BIT]);
  endproperty
  a_peak_open: assert property (p_peak_open)
    else $error("Peak bit did not follow an allowed write");
  property p_second_local_bus_mode_follows;
    @(posedge mclk_i) disable iff (reset_i)
    (wr_aux && !restart_entry_i && !failsafe_entry_i)
      |=> second_local_bus_mode_o == $past(fr.wdata[`BTMC_SECOND_LOCAL_BUS_MODE_HI:`BTMC_SECOND_LOCAL_BUS_MODE_LO]);
  endproperty
  a_second_local_bus_mode_follows: assert property (p_second_local_bus_mode_follows)
    else $error("Second LIN mode did not follow write");
  property p_ctrl_readback;
    @(posedge mclk_i) disable iff (reset_i)
    (fr.rd_addr == `BTMC_ADDR_BUS_CTRL) |-> fr.rdata == {lin_flash_o, low_slope_select_o,
      transmit_timeout_enable_o, lin_mode_o, selective_wake_o, can_mode_o};
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("Control register read differs from applied modes");
endmodule // btmc_regs

// file: rtl/btmc_consts.svh
// Constants of the bus transceiver mode control block
`ifndef BTMC_CONSTS_SVH
`define BTMC_CONSTS_SVH
`define BTMC_ADDR_BUS_CTRL 7'h04
`define BTMC_ADDR_BUS_AUX 7'h05
`define BTMC_BUS_CTRL_RST 8'h20
`define BTMC_BUS_AUX_RST 8'h00
`define BTMC_BUS_AUX_FS 8'h01
`define BTMC_FLASH_BIT 7
`define BTMC_LSM_BIT 6
`define BTMC_TXTO_BIT 5
`define BTMC_LIN1_HI 4
`define BTMC_LIN1_LO 3
`define BTMC_SWK_BIT 2
`define BTMC_CAN_HI 1
`define BTMC_CAN_LO 0
`define BTMC_PEAK_BIT 5
`define BTMC_SECOND_LOCAL_BUS_MODE_HI 1
`define BTMC_SECOND_LOCAL_BUS_MODE_LO 0
`define BTMC_MODE_OFF 2'h0
`define BTMC_MODE_WAKE 2'h1
`define BTMC_MODE_RX 2'h2
`define BTMC_MODE_NORMAL 2'h3
`define BTMC_FRAME_BITS 5'h10
`define BTMC_ADDR_BITS 5'h08
`define BTMC_CNT_MAX 5'h1F
`define BTMC_WR_BIT 15
`define BTMC_AUX_ZERO_MASK 8'hDC
`endif

// file: rtl/btmc_pkg.sv
// Types of the bus transceiver mode control block
package btmc_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_shift = 2'b10
  } btmc_state_t;
  typedef logic [1:0] btmc_mode_t;
endpackage

// file: rtl/btmc_frame_if.sv
// Frame results passed from the serial port to the register bank
`timescale 1ns/1ps
interface btmc_frame_if;
  logic frame_done;
  logic frame_ok;
  logic is_write;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [6:0] rd_addr;
  logic [7:0] rdata;
  modport port_side (output frame_done, frame_ok, is_write, addr, wdata, rd_addr, input rdata);
  modport reg_side (input frame_done, frame_ok, is_write, addr, wdata, rd_addr, output rdata);
endinterface

// file: rtl/btmc_spi_frame.sv
// Serial register port: synchronisers, frame shifter and read return
`timescale 1ns/1ps
`include "btmc_consts.svh"
module btmc_spi_frame (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic chip_select_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  btmc_frame_if.port_side fr
);
  // ****************************************
  // Synchronisers
  // ****************************************
  logic csn_s1_ff, csn_s2_ff, sclk_s1_ff, sclk_s2_ff, sdi_s1_ff, sdi_s2_ff, sclk_d_ff;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      csn_s1_ff <= 1'b1;
      csn_s2_ff <= 1'b1;
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sdi_s1_ff <= 1'b0;
      sdi_s2_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
    end else begin
      csn_s1_ff <= chip_select_n_i;
      csn_s2_ff <= csn_s1_ff;
      sclk_s1_ff <= sclk_i;
      sclk_s2_ff <= sclk_s1_ff;
      sdi_s1_ff <= sdi_i;
      sdi_s2_ff <= sdi_s1_ff;
      sclk_d_ff <= sclk_s2_ff;
    end
  end
  // ****************************************
  // Frame shifter
  // ****************************************
  btmc_pkg::btmc_state_t st_ff, nxt_st;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [15:0] rx_ff, nxt_rx;
  logic [7:0] tx_ff, nxt_tx;
  logic done_ff, nxt_done, ok_ff, nxt_ok, wr_ff, nxt_wr;
  logic [6:0] addr_ff, nxt_addr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic sdo_ff, nxt_sdo, oe_ff, nxt_oe, rise, fall;
  assign rise = sclk_s2_ff & ~sclk_d_ff;
  assign fall = ~sclk_s2_ff & sclk_d_ff;
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_rx = rx_ff;
    nxt_tx = tx_ff;
    nxt_done = 1'b0;
    nxt_ok = ok_ff;
    nxt_wr = wr_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    case (st_ff)
      btmc_pkg::st_idle: begin
        if (!csn_s2_ff) begin
          nxt_st = btmc_pkg::st_shift;
          nxt_cnt = 5'h00;
          nxt_tx = 8'h00;
        end
      end
      btmc_pkg::st_shift: begin
        if (csn_s2_ff) begin
          // Commit only when the select returns high
          nxt_st = btmc_pkg::st_idle;
          nxt_done = 1'b1;
          nxt_ok = (cnt_ff == `BTMC_FRAME_BITS);
          nxt_wr = rx_ff[`BTMC_WR_BIT];
          nxt_addr = rx_ff[14:8];
          nxt_wdata = rx_ff[7:0];
        end else if (rise) begin
          nxt_rx = {rx_ff[14:0], sdi_s2_ff};
          if (cnt_ff != `BTMC_CNT_MAX) begin
            nxt_cnt = cnt_ff + 5'h01;
          end
        end else if (fall) begin
          // Read data loads on the falling edge after the address byte
          if (cnt_ff == `BTMC_ADDR_BITS) begin
            nxt_tx = fr.rdata;
          end else begin
            nxt_tx = {tx_ff[6:0], 1'b0};
          end
        end
      end
      default: nxt_st = btmc_pkg::st_idle;
    endcase
    nxt_sdo = nxt_tx[7];
    nxt_oe = (nxt_st == btmc_pkg::st_shift);
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff <= btmc_pkg::st_idle;
      cnt_ff <= 5'h00;
      rx_ff <= 16'h0000;
      tx_ff <= 8'h00;
      done_ff <= 1'b0;
      ok_ff <= 1'b0;
      wr_ff <= 1'b0;
      addr_ff <= 7'h00;
      wdata_ff <= 8'h00;
      sdo_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
      done_ff <= nxt_done;
      ok_ff <= nxt_ok;
      wr_ff <= nxt_wr;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      sdo_ff <= nxt_sdo;
      oe_ff <= nxt_oe;
    end
  end
  assign fr.frame_done = done_ff;
  assign fr.frame_ok = ok_ff;
  assign fr.is_write = wr_ff;
  assign fr.addr = addr_ff;
  assign fr.wdata = wdata_ff;
  assign fr.rd_addr = rx_ff[6:0];
  assign sdo_o = sdo_ff;
  assign sdo_oe_o = oe_ff;
  // ****************************************
  // Assertions
  // ****************************************
  sequence s_cs_release;
    $rose(chip_select_n_i) && (st_ff == btmc_pkg::st_shift) && !csn_s1_ff;
  endsequence
  property p_commit_at_release;
    @(posedge mclk_i) disable iff (reset_i)
    s_cs_release |-> ##3 done_ff;
  endproperty
  a_commit_at_release: assert property (p_commit_at_release)
    else $error("Frame not committed three cycles after select release");
endmodule // btmc_spi_frame

// file: verification/btmc_host_model.sv
// Host model: serial register port master, mode 0, MSB first
`timescale 1ns/1ps
module btmc_host_model (
  input wire logic mclk_i,
  input wire logic sdo_i,
  output logic chip_select_n_o,
  output logic sclk_o,
  output logic sdi_o,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o
);
  initial begin
    chip_select_n_o = 1'h1;
    sclk_o = 1'h0;
    sdi_o = 1'h0;
    rd_valid_o = 1'h0;
    rd_data_o = 8'h00;
  end
  // ****************
  // Frame tasks
  // ****************
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask
  // Four mclk per phase: above the 3-cycle minimum, 200 ns clock period
  task automatic xfer(input logic [15:0] frame, input int nbits);
    logic [7:0] rd;
    rd = 8'h00;
    step(1);
    chip_select_n_o = 1'h0;
    for (int i = 15; i > 15 - nbits; i--) begin
      sdi_o = frame[i];
      step(4);
      if (i < 8) rd[i] = sdo_i;
      sclk_o = 1'h1;
      step(4);
      sclk_o = 1'h0;
    end
    step(4);
    chip_select_n_o = 1'h1;
    // Released data line shows the inverse, never a stale value
    sdi_o = ~sdi_o;
    rd_data_o = rd;
    rd_valid_o = (nbits == 16) && !frame[15];
    step(1);
    rd_valid_o = 1'h0;
    step(8);
  endtask
endmodule // btmc_host_model

// file: verification/tb_top.sv
// Self-checking testbench of the bus transceiver mode control registers
`timescale 1ns/1ps
`include "btmc_consts.svh"
module tb_top;
  logic mclk_i = 1'h0;
  logic reset_i = 1'h1;
  logic cs_n, sclk, sdi, sdo, sdo_oe, rd_valid, spi_fail, ext_load, int_out;
  logic [7:0] rd_data, v, a, e;
  wire [7:0] bus_out, aux_out;
  logic init_normal = 1'h1, stop_mode = 1'h0, sys_err = 1'h0, glob = 1'h0;
  logic sleep_p = 1'h0, stop_p = 1'h0, fs_p = 1'h0, rs_p = 1'h0;
  logic wake_ev = 1'h0, stat_ev = 1'h0;
  logic [1:0] rs_lin = 2'h0, rs_can = 2'h0, rs_second_local_bus_mode = 2'h0;
  logic [7:0] exp_q[$];
  int err_count = 0;
  int tests_run = 0;
  int fails_seen = 0;
  int seed;
  always #12.5 mclk_i = ~mclk_i;
  assign {aux_out[7:6], aux_out[4:2]} = 5'h00;
  btmc_host_model u_host (.mclk_i(mclk_i), .sdo_i(sdo), .chip_select_n_o(cs_n),
    .sclk_o(sclk), .sdi_o(sdi), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
  btmc_regs u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .chip_select_n_i(cs_n),
    .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .init_normal_mode_i(init_normal), .stop_mode_i(stop_mode),
    .system_error_flag_i(sys_err), .sleep_entry_i(sleep_p), .stop_entry_i(stop_p),
    .failsafe_entry_i(fs_p), .restart_entry_i(rs_p), .restart_lin_mode_i(rs_lin),
    .restart_can_mode_i(rs_can), .restart_second_lin_mode_i(rs_second_local_bus_mode),
    .wake_event_i(wake_ev), .status_event_i(stat_ev), .global_interrupt_i(glob),
    .lin_flash_o(bus_out[7]), .low_slope_select_o(bus_out[6]),
    .transmit_timeout_enable_o(bus_out[5]), .lin_mode_o(bus_out[4:3]),
    .can_mode_o(bus_out[1:0]), .selective_wake_o(bus_out[2]),
    .second_local_bus_mode_o(aux_out[1:0]), .regulator_peak_threshold_o(aux_out[5]),
    .spi_fail_o(spi_fail), .external_wake_load_o(ext_load), .int_o(int_out));
  // ****************
  // Checking
  // ****************
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge mclk_i) begin
    if (spi_fail === 1'h1) fails_seen++;
    if (rd_valid === 1'h1) begin
      if (exp_q.size() > 0) cmp8(rd_data, exp_q.pop_front());
      else cmp8(rd_data, ~rd_data);
    end
  end
  task automatic conclude();
    $display("Checks: %0d, mismatches: %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Roughly 130 frames of 3.55 us each; twice that margin
  initial begin
    #1ms;
    err_count++;
    conclude();
  end
  // ****************
  // Stimulus
  // ****************
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    u_host.xfer({1'h1, ad, d}, 16);
  endtask
  task automatic rd(input logic [6:0] ad, input logic [7:0] x);
    exp_q.push_back(x);
    u_host.xfer({1'h0, ad, 8'h00}, 16);
  endtask
  task automatic chk(input logic [7:0] c, input logic [7:0] x);
    cmp8(bus_out, c);
    cmp8(aux_out, x);
    rd(`BTMC_ADDR_BUS_CTRL, c);
    rd(`BTMC_ADDR_BUS_AUX, x);
  endtask
  task automatic pulse(ref logic p);
    p = 1'h1;
    tick(1);
    p = 1'h0;
  endtask
  initial begin
    seed = $urandom(90);
    tick(5);
    reset_i = 1'h0;
    tick(1);
    chk(8'h20, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = {3'($urandom), 2'(i), 3'(i)};
      wr(`BTMC_ADDR_BUS_CTRL, v);
      chk(v, 8'h00);
    end
    wr(`BTMC_ADDR_BUS_AUX, 8'hFF);
    chk(v, 8'h23);
    init_normal = 1'h0;
    stop_mode = 1'h1;
    glob = 1'h1;
    wr(`BTMC_ADDR_BUS_AUX, 8'h02);
    chk(v, 8'h22);
    cmp8(8'(fails_seen), 8'h00);
    cmp8({7'h00, int_out}, 8'h00);
    init_normal = 1'h1;
    stop_mode = 1'h0;
    glob = 1'h0;
    for (int i = 0; i < 24; i++) begin
      sys_err = (i >= 16);
      v = {3'h1, 2'h3, 3'(i)};
      e = v;
      if (i / 8 != 1 && v[1] && !(sys_err && v[0])) e[1:0] = 2'h1;
      wr(`BTMC_ADDR_BUS_CTRL, v);
      if (i / 8 == 1) pulse(stop_p);
      else pulse(sleep_p);
      chk(e, 8'h22);
    end
    sys_err = 1'h0;
    wr(`BTMC_ADDR_BUS_CTRL, 8'hFE);
    wr(`BTMC_ADDR_BUS_AUX, 8'h23);
    pulse(fs_p);
    cmp8({7'h00, ext_load}, 8'h01);
    chk(8'hED, 8'h01);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      a = {2'h0, 1'($urandom), 3'h0, 2'($urandom)};
      {rs_lin, rs_can, rs_second_local_bus_mode} = 6'($urandom);
      wr(`BTMC_ADDR_BUS_CTRL, v);
      wr(`BTMC_ADDR_BUS_AUX, a);
      pulse(rs_p);
      chk({v[7:5], rs_lin, v[2], rs_can}, {a[7:2], rs_second_local_bus_mode});
    end
    v = bus_out;
    u_host.xfer({1'h1, `BTMC_ADDR_BUS_CTRL, ~v}, 15);
    cmp8(8'(fails_seen), 8'h01);
    wr(7'h7F, 8'hFF);
    rd(7'h7F, 8'h00);
    chk(v, {a[7:2], rs_second_local_bus_mode});
    for (int i = 0; i < 8; i++) begin
      {glob, stat_ev, wake_ev} = 3'(i);
      tick(1);
      {stat_ev, wake_ev} = 2'h0;
      cmp8({7'h00, int_out}, {7'h00, i[0] | (i[2] & i[1])});
      tick(1);
    end
    tick(4);
    cmp8(8'(exp_q.size()), 8'h00);
    conclude();
  end
endmodule // tb_top
